// ==== reload_timers_map.svh ====
// Register map, field positions, reset values and timing counts for the reload timers.
// Assumes a 32-bit Avalon-MM slave with word addressing by printed register index.
// Notes on behaviour
// [R01] Each timer: 16-bit counter, two 8-bit preload bytes
// [R02] Enabled counter decrements once per count pulse
// [R03] Interrupt raised when counter wraps 0000H to FFFFH
// [R04] Timer one reloads from its preload bytes
// [R05] Preload N gives N+1 pulses between interrupts
// [R06] Reset clears counters; enable then underflows immediately
// [R07] Software writes preloads before enabling a timer
// [R08] Timer one counts slow clock, fast in fast-only
// [R09] Timer two counts system clock divided by 1.5
// [R10] Interrupt enable bit 2 gates timer one
// [R11] Interrupt enable bit 1 gates timer two
// [R12] Control bit 2 runs timer one, reset 0
// [R13] Control bit 3 runs timer two, reset 0
// [R14] Timer one preload low 0x03, high 0x04
// [R15] Timer two preload low 0x05, high 0x06
// [R16] Timer two reloads like timer one
// [R17] Preload writes leave running counter untouched
`ifndef RELOAD_TIMERS_MAP_SVH
`define RELOAD_TIMERS_MAP_SVH

`define IDX_IRQ_ENABLE 4'h2
`define IDX_T1_LOW 4'h3
`define IDX_T1_HIGH 4'h4
`define IDX_T2_LOW 4'h5
`define IDX_T2_HIGH 4'h6
`define IDX_OP_CTRL 4'h9
`define IDX_IRQ_STATUS 4'hB
`define IDX_IRQ_MASK 4'hC
`define IDX_COUNT_ONE 4'hD
`define IDX_COUNT_TWO 4'hE
`define IDX_CLK_MODE 4'hF

`define BIT_T1_IRQ 2
`define BIT_T2_IRQ 1
`define BIT_T1_RUN 2
`define BIT_T2_RUN 3

`define RST_BYTE 8'h00
`define RST_COUNT 16'h0000
`define RST_MODE 2'h0

`define FAST_HZ 4000000
`define SLOW_HZ 32768
`define SYS_HZ 100000000

`endif

// ==== reload_timers_pkg.sv ====
// Types shared by the reload timer block.
// Assumes the map header carries all numeric constants.
package reload_timers_pkg;
    typedef enum logic [1:0] {
        MODE_DUAL,
        MODE_SLOW_ONLY,
        MODE_FAST_ONLY
    } clk_mode_t;
endpackage : reload_timers_pkg

// ==== down_reload_counter.sv ====
// One 16-bit auto-reload down counter with an underflow pulse.
// Assumes a one-cycle count enable on the same clock.
`timescale 1ns/1ps
module down_reload_counter #(
    parameter int WIDTH = 16
) (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic run,
    input wire logic tick,
    input wire logic [WIDTH-1:0] preload,
    output logic [WIDTH-1:0] count_q,
    output logic underflow
);
    if (WIDTH < 2)
    begin : g_bad_width
        $error("WIDTH too small");
    end

    wire step = run & tick; // R02
    wire wrap = step & (count_q == '0); // R03

    // Reload takes the place of the FFFFH state
    always_ff @(posedge sys_clk)
    begin
        if (srst)
            count_q <= '0; // R06
        else if (wrap)
            count_q <= preload; // R04 R05 R16 R17
        else if (step)
            count_q <= count_q - WIDTH'(1); // R02
    end

    assign underflow = wrap; // R03

    a_zero_wrap_reload: assert property (@(posedge sys_clk) disable iff (srst) // R04
        (run && tick && count_q == '0) |=> (count_q == $past(preload)))
        else $error("reload missed on underflow");
    a_step_by_one: assert property (@(posedge sys_clk) disable iff (srst) // R02
        (run && tick && count_q != '0) |=> (count_q == $past(count_q) - WIDTH'(1)))
        else $error("counter did not step by one");
    a_hold_idle: assert property (@(posedge sys_clk) disable iff (srst) // R17
        !(run && tick) |=> $stable(count_q))
        else $error("counter moved without a tick");
endmodule : down_reload_counter

// ==== reload_timers.sv ====
// Two auto-reload down timers behind an Avalon-MM slave.
// Assumes slow and fast count rates are derived here from sys_clk by dividers.
`timescale 1ns/1ps
`include "reload_timers_map.svh"
module reload_timers #(
    parameter int SLOW_DIV = `SYS_HZ / `SLOW_HZ,
    parameter int FAST_DIV = `SYS_HZ / `FAST_HZ
) (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic irq
);
    if (SLOW_DIV < 3 || FAST_DIV < 2)
    begin : g_bad_div
        $error("divider too small");
    end

    logic [7:0] irq_en_q;
    logic [7:0] op_ctrl_q;
    logic [7:0] t1_low_q, t1_high_q, t2_low_q, t2_high_q;
    logic [1:0] irq_stat_q;
    logic [1:0] irq_mask_q;
    reload_timers_pkg::clk_mode_t mode_q;
    logic [31:0] rdata_q;
    logic ack_q;
    logic [31:0] slow_cnt_q, fast_cnt_q;
    logic [1:0] sys_ph_q;
    logic [31:0] sys_cnt_q;
    logic slow_tick, fast_tick, sys_tick, t1_tick, t2_tick;
    logic [15:0] count_one, count_two;
    logic uf_one, uf_two;

    // Decoding
    function automatic logic hit(input logic [3:0] a, input logic [3:0] idx);
        hit = (a == idx);
    endfunction : hit

    // One-cycle wait so read data always come from a register
    wire req = (avs_read | avs_write) & ~ack_q;
    assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
    wire wr = avs_write & ack_q & avs_byteenable[0];
    wire [7:0] wb = avs_writedata[7:0];
    wire t1_irq_ev = uf_one & irq_en_q[`BIT_T1_IRQ]; // R10
    wire t2_irq_ev = uf_two & irq_en_q[`BIT_T2_IRQ]; // R11
    wire [1:0] stat_clr = (wr && hit(avs_address, `IDX_IRQ_STATUS)) ? wb[1:0] : 2'h0;
    wire [1:0] events = {t1_irq_ev, t2_irq_ev};

    always_ff @(posedge sys_clk)
    begin
        if (srst)
            ack_q <= 1'b0;
        else
            ack_q <= req;
    end

    // Write side: control and preload bytes only; counters keep running
    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            irq_en_q <= `RST_BYTE;
            op_ctrl_q <= `RST_BYTE; // R12 R13
            t1_low_q <= `RST_BYTE;
            t1_high_q <= `RST_BYTE;
            t2_low_q <= `RST_BYTE;
            t2_high_q <= `RST_BYTE;
            irq_mask_q <= 2'h0;
            mode_q <= reload_timers_pkg::MODE_DUAL;
        end
        else if (wr)
        begin
            if (hit(avs_address, `IDX_IRQ_ENABLE)) irq_en_q <= wb; // R10 R11
            if (hit(avs_address, `IDX_T1_LOW)) t1_low_q <= wb; // R14 R17
            if (hit(avs_address, `IDX_T1_HIGH)) t1_high_q <= wb; // R14 R17
            if (hit(avs_address, `IDX_T2_LOW)) t2_low_q <= wb; // R15 R17
            if (hit(avs_address, `IDX_T2_HIGH)) t2_high_q <= wb; // R15 R17
            if (hit(avs_address, `IDX_OP_CTRL)) op_ctrl_q <= wb; // R12 R13
            if (hit(avs_address, `IDX_IRQ_MASK)) irq_mask_q <= wb[1:0];
            if (hit(avs_address, `IDX_CLK_MODE))
            begin
                case (wb[1:0])
                    2'h1: mode_q <= reload_timers_pkg::MODE_SLOW_ONLY;
                    2'h2: mode_q <= reload_timers_pkg::MODE_FAST_ONLY;
                    default: mode_q <= reload_timers_pkg::MODE_DUAL;
                endcase
            end
        end
    end

    // Set wins over a same-cycle clear
    always_ff @(posedge sys_clk)
    begin
        if (srst)
            irq_stat_q <= 2'h0;
        else
            irq_stat_q <= (irq_stat_q & ~stat_clr) | events; // R03
    end

    assign irq = |(irq_stat_q & irq_mask_q);

    // Preload registers read back as zero: they are write-only
    wire [31:0] rmux =
        hit(avs_address, `IDX_IRQ_ENABLE) ? {24'h0, irq_en_q} :
        hit(avs_address, `IDX_OP_CTRL) ? {24'h0, op_ctrl_q} :
        hit(avs_address, `IDX_IRQ_STATUS) ? {30'h0, irq_stat_q} :
        hit(avs_address, `IDX_IRQ_MASK) ? {30'h0, irq_mask_q} :
        hit(avs_address, `IDX_COUNT_ONE) ? {16'h0, count_one} :
        hit(avs_address, `IDX_COUNT_TWO) ? {16'h0, count_two} :
        hit(avs_address, `IDX_CLK_MODE) ? {30'h0, mode_q} : 32'h0;

    always_ff @(posedge sys_clk)
    begin
        if (srst)
            rdata_q <= 32'h0;
        else if (avs_read & ~ack_q)
            rdata_q <= rmux;
    end

    assign avs_readdata = rdata_q;

    // Count-rate dividers
    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            slow_cnt_q <= 32'h0;
            fast_cnt_q <= 32'h0;
        end
        else
        begin
            slow_cnt_q <= slow_tick ? 32'h0 : slow_cnt_q + 32'h1;
            fast_cnt_q <= fast_tick ? 32'h0 : fast_cnt_q + 32'h1;
        end
    end

    assign slow_tick = (slow_cnt_q == 32'(SLOW_DIV - 1));
    assign fast_tick = (fast_cnt_q == 32'(FAST_DIV - 1));

    // System clock is the fast rate unless the slow clock alone runs the core
    wire sys_rate = (mode_q == reload_timers_pkg::MODE_SLOW_ONLY) ? slow_tick : fast_tick;

    // Divide by 1.5: two ticks out of every three system pulses
    always_ff @(posedge sys_clk)
    begin
        if (srst)
            sys_ph_q <= 2'h0;
        else if (sys_rate)
            sys_ph_q <= (sys_ph_q == 2'h2) ? 2'h0 : sys_ph_q + 2'h1;
    end

    assign sys_tick = sys_rate & (sys_ph_q != 2'h2); // R09
    assign t2_tick = sys_tick; // R09
    assign t1_tick = (mode_q == reload_timers_pkg::MODE_FAST_ONLY) ? fast_tick : slow_tick; // R08

    down_reload_counter #(.WIDTH(16)) u_timer_one (
        .sys_clk(sys_clk),
        .srst(srst),
        .run(op_ctrl_q[`BIT_T1_RUN]), // R12
        .tick(t1_tick),
        .preload({t1_high_q, t1_low_q}), // R01 R04
        .count_q(count_one),
        .underflow(uf_one)
    );

    down_reload_counter #(.WIDTH(16)) u_timer_two (
        .sys_clk(sys_clk),
        .srst(srst),
        .run(op_ctrl_q[`BIT_T2_RUN]), // R13
        .tick(t2_tick),
        .preload({t2_high_q, t2_low_q}), // R01 R16
        .count_q(count_two),
        .underflow(uf_two)
    );

    // Helper: cycles since the last timer two count pulse
    always_ff @(posedge sys_clk)
    begin
        if (srst)
            sys_cnt_q <= 32'h0;
        else
            sys_cnt_q <= t2_tick ? 32'h0 : sys_cnt_q + 32'h1;
    end

    // Rule checks on the timers
    a_irq_gate_one: assert property (@(posedge sys_clk) disable iff (srst) // R10
        (uf_one && irq_en_q[2]) |=> irq_stat_q[1])
        else $error("timer one event lost");
    a_irq_block_one: assert property (@(posedge sys_clk) disable iff (srst) // R10
        (!irq_stat_q[1] && !(uf_one && irq_en_q[2])) |=> !irq_stat_q[1] || $past(1'b0))
        else $error("timer one status set without event");
    a_irq_gate_two: assert property (@(posedge sys_clk) disable iff (srst) // R11
        (uf_two && irq_en_q[1]) |=> irq_stat_q[0])
        else $error("timer two event lost");
    a_run_stop_one: assert property (@(posedge sys_clk) disable iff (srst) // R12
        !op_ctrl_q[2] |=> $stable(count_one))
        else $error("timer one moved while stopped");
    a_run_stop_two: assert property (@(posedge sys_clk) disable iff (srst) // R13
        !op_ctrl_q[3] |=> $stable(count_two))
        else $error("timer two moved while stopped");
    a_wrap_at_zero: assert property (@(posedge sys_clk) disable iff (srst) // R03
        uf_one |-> count_one == 16'h0000)
        else $error("timer one underflow off zero");
    a_reset_clear: assert property (@(posedge sys_clk) // R06
        srst |=> (count_one == 16'h0000 && count_two == 16'h0000))
        else $error("counters not cleared by reset");
    a_two_thirds: assert property (@(posedge sys_clk) disable iff (srst) // R09
        (sys_rate && sys_ph_q == 2'h2) |-> !t2_tick)
        else $error("timer two rate not divided by 1.5");
    a_preload_iso: assert property (@(posedge sys_clk) disable iff (srst) // R17
        (wr && hit(avs_address, `IDX_T1_LOW) && !(t1_tick && op_ctrl_q[2])) |=>
        $stable(count_one))
        else $error("preload write disturbed counter");

    // Multi-step behaviours are built from these sequences
    sequence s_access_open;
        (avs_read || avs_write) && !ack_q;
    endsequence

    sequence s_access_close;
        ack_q && !avs_waitrequest;
    endsequence

    sequence s_one_event;
        uf_one && irq_en_q[`BIT_T1_IRQ];
    endsequence

    sequence s_two_event;
        uf_two && irq_en_q[`BIT_T2_IRQ];
    endsequence

    sequence s_one_clear;
        wr && hit(avs_address, `IDX_IRQ_STATUS) && wb[1];
    endsequence

    sequence s_two_clear;
        wr && hit(avs_address, `IDX_IRQ_STATUS) && wb[0];
    endsequence

    // Register bus: fixed two-cycle access
    a_bus_two_cycle: assert property (@(posedge sys_clk) disable iff (srst)
        s_access_open |-> avs_waitrequest ##1 s_access_close)
        else $error("access not answered in its second cycle");

    a_rdata_hold: assert property (@(posedge sys_clk) disable iff (srst)
        !(avs_read && !ack_q) |=> $stable(avs_readdata))
        else $error("read data moved without a read");

    a_preload_wo: assert property (@(posedge sys_clk) disable iff (srst) // R14 R15
        (avs_read && !ack_q && avs_address inside {[`IDX_T1_LOW:`IDX_T2_HIGH]}) |=>
        avs_readdata == 32'h0)
        else $error("write-only preload read back nonzero");

    // Register writes land in the cycle after the accepting edge
    a_t1_low_write: assert property (@(posedge sys_clk) disable iff (srst) // R14
        (wr && hit(avs_address, `IDX_T1_LOW)) |=> t1_low_q == $past(wb))
        else $error("timer one low preload not written");

    a_t1_high_write: assert property (@(posedge sys_clk) disable iff (srst) // R14
        (wr && hit(avs_address, `IDX_T1_HIGH)) |=> t1_high_q == $past(wb))
        else $error("timer one high preload not written");

    a_t2_low_write: assert property (@(posedge sys_clk) disable iff (srst) // R15
        (wr && hit(avs_address, `IDX_T2_LOW)) |=> t2_low_q == $past(wb))
        else $error("timer two low preload not written");

    a_t2_high_write: assert property (@(posedge sys_clk) disable iff (srst) // R15
        (wr && hit(avs_address, `IDX_T2_HIGH)) |=> t2_high_q == $past(wb))
        else $error("timer two high preload not written");

    a_ctrl_write: assert property (@(posedge sys_clk) disable iff (srst) // R12 R13
        (wr && hit(avs_address, `IDX_OP_CTRL)) |=> op_ctrl_q == $past(wb))
        else $error("control register not written");

    a_irq_en_write: assert property (@(posedge sys_clk) disable iff (srst) // R10 R11
        (wr && hit(avs_address, `IDX_IRQ_ENABLE)) |=> irq_en_q == $past(wb))
        else $error("interrupt enable not written");

    a_mask_write: assert property (@(posedge sys_clk) disable iff (srst)
        (wr && hit(avs_address, `IDX_IRQ_MASK)) |=> irq_mask_q == $past(wb[1:0]))
        else $error("interrupt mask not written");

    // Byte lane 0 carries every field, so without it a write is dropped
    a_be_ignored: assert property (@(posedge sys_clk) disable iff (srst)
        (avs_write && ack_q && !avs_byteenable[0]) |=> $stable(op_ctrl_q) && $stable(irq_en_q))
        else $error("write without byte lane 0 acted");

    a_reset_regs: assert property (@(posedge sys_clk) // R06 R10 R11 R12 R13
        srst |=> (op_ctrl_q == 8'h00 && irq_en_q == 8'h00 && irq_stat_q == 2'h0))
        else $error("control registers not cleared by reset");

    // Interrupt path: event, sticky status, masked level
    a_irq_block_two: assert property (@(posedge sys_clk) disable iff (srst) // R11
        (!irq_stat_q[0] && !(uf_two && irq_en_q[`BIT_T2_IRQ])) |=> !irq_stat_q[0])
        else $error("timer two status set without event");

    a_irq_out_one: assert property (@(posedge sys_clk) disable iff (srst) // R10
        s_one_event ##1 irq_mask_q[1] |-> irq)
        else $error("timer one interrupt not raised");

    a_irq_out_two: assert property (@(posedge sys_clk) disable iff (srst) // R11
        s_two_event ##1 irq_mask_q[0] |-> irq)
        else $error("timer two interrupt not raised");

    a_clear_one: assert property (@(posedge sys_clk) disable iff (srst) // R03
        s_one_clear ##0 !t1_irq_ev |=> !irq_stat_q[1])
        else $error("timer one status not cleared");

    a_clear_two: assert property (@(posedge sys_clk) disable iff (srst) // R03
        s_two_clear ##0 !t2_irq_ev |=> !irq_stat_q[0])
        else $error("timer two status not cleared");

    a_set_beats_one: assert property (@(posedge sys_clk) disable iff (srst) // R03
        s_one_clear ##0 t1_irq_ev |=> irq_stat_q[1])
        else $error("timer one event lost to a clear");

    a_set_beats_two: assert property (@(posedge sys_clk) disable iff (srst) // R03
        s_two_clear ##0 t2_irq_ev |=> irq_stat_q[0])
        else $error("timer two event lost to a clear");

    // Count sources and timer two
    a_wrap_two_zero: assert property (@(posedge sys_clk) disable iff (srst) // R16
        uf_two |-> count_two == 16'h0000)
        else $error("timer two underflow off zero");

    a_preload_iso_two: assert property (@(posedge sys_clk) disable iff (srst) // R17
        (wr && hit(avs_address, `IDX_T2_LOW) && !(t2_tick && op_ctrl_q[3])) |=>
        $stable(count_two))
        else $error("preload write disturbed timer two");

    // Loose bound: mode writes may switch the rate source mid-period once or twice
    a_t2_gap: assert property (@(posedge sys_clk) disable iff (srst) // R09
        sys_cnt_q < 32'(4 * (SLOW_DIV + FAST_DIV)))
        else $error("timer two count pulses stopped");

    a_t1_slow_src: assert property (@(posedge sys_clk) disable iff (srst) // R08
        (mode_q != reload_timers_pkg::MODE_FAST_ONLY && !slow_tick) |=> $stable(count_one))
        else $error("timer one moved off the slow rate");

    a_t1_fast_src: assert property (@(posedge sys_clk) disable iff (srst) // R08
        (mode_q == reload_timers_pkg::MODE_FAST_ONLY && !fast_tick) |=> $stable(count_one))
        else $error("timer one moved off the fast rate");
endmodule : reload_timers

// ==== cpu_bus_master.sv ====
// Avalon-MM master standing in for the CPU core that programs the timers.
// Assumes the slave raises waitrequest in the first cycle of each request.
`timescale 1ns/1ps
module cpu_bus_master (
    input wire logic sys_clk,
    input wire logic avs_waitrequest,
    input wire logic [31:0] avs_readdata,
    output logic [3:0] avs_address,
    output logic avs_read,
    output logic avs_write,
    output logic [31:0] avs_writedata,
    output logic [3:0] avs_byteenable
);
    initial
    begin
        avs_address = 4'h0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        avs_byteenable = 4'hF;
    end

    // Released lines are scrambled so stale values cannot pass for data
    task automatic xfer(input logic wr, input logic [3:0] a, input logic [7:0] d,
        input logic [3:0] be, output logic [31:0] rd);
        @(posedge sys_clk);
        avs_address <= a;
        avs_read <= !wr;
        avs_write <= wr;
        avs_writedata <= {24'h0, d};
        avs_byteenable <= be;
        do
            @(posedge sys_clk);
        while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        avs_address <= ~a;
        avs_writedata <= {24'hA5A5A5, ~d};
    endtask : xfer
endmodule : cpu_bus_master

// ==== tb_top.sv ====
// Self-checking bench for the reload timers, driven through the CPU bus model.
// Assumes shortened dividers; every expected span scales with them.
`timescale 1ns/1ps
`include "reload_timers_map.svh"
module tb_top;
    localparam int SDIV = 4;
    localparam int FDIV = 2;
    logic sys_clk = 1'b0;
    logic srst = 1'b1;
    logic [3:0] avs_address, avs_byteenable;
    logic avs_read, avs_write, avs_waitrequest, irq, irq_prev = 1'b0;
    logic [31:0] avs_writedata, avs_readdata, v0, v1;
    int exp_reg [16] = '{default: 0};
    int rises [$];
    int cyc = 0, num_errors = 0, n_checks = 0;

    always #5 sys_clk = ~sys_clk;

    cpu_bus_master u_cpu_bus_master (.sys_clk(sys_clk), .avs_waitrequest(avs_waitrequest),
        .avs_readdata(avs_readdata), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable));
    reload_timers #(.SLOW_DIV(SDIV), .FAST_DIV(FDIV)) u_reload_timers (.sys_clk(sys_clk),
        .srst(srst), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq));

    always @(posedge sys_clk)
    begin
        if (irq === 1'b1 && irq_prev !== 1'b1)
            rises.push_back(cyc);
        irq_prev <= irq;
        cyc <= cyc + 1;
    end

    task automatic close_out();
        if (num_errors == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : close_out

    task automatic chk_reg(input logic [3:0] a, input logic [31:0] e, input logic [31:0] s);
        n_checks++;
        if (s !== e)
        begin
            num_errors++;
            $display("Error reg %0h expected %0h seen %0h", a, e, s);
        end
    endtask : chk_reg

    task automatic chk_val(input string nm, input int e, input int s);
        n_checks++;
        if (s != e)
        begin
            num_errors++;
            $display("Error %s expected %0d seen %0d", nm, e, s);
        end
    endtask : chk_val

    function automatic logic [7:0] wmask(input int a);
        case (a)
            `IDX_IRQ_ENABLE: return 8'h06;
            `IDX_OP_CTRL: return 8'hF3;
            `IDX_IRQ_MASK: return 8'h03;
            `IDX_CLK_MODE: return 8'h01;
            default: return 8'hFF;
        endcase
    endfunction : wmask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        logic [31:0] v;
        u_cpu_bus_master.xfer(1'b1, a, d, 4'hF, v);
        if (a inside {`IDX_IRQ_ENABLE, `IDX_OP_CTRL, `IDX_IRQ_MASK, `IDX_CLK_MODE})
            exp_reg[a] = d;
    endtask : wr

    task automatic rd(input logic [3:0] a, output logic [31:0] v);
        u_cpu_bus_master.xfer(1'b0, a, 8'h00, 4'hF, v);
    endtask : rd

    task automatic rd_chk(input logic [3:0] a);
        logic [31:0] v;
        rd(a, v);
        chk_reg(a, exp_reg[a], v);
    endtask : rd_chk

    // Starts on a falling edge so a just-cleared flag is not seen stale
    task automatic wait_irq();
        int n;
        n = 0;
        @(negedge sys_clk);
        while (irq !== 1'b1 && n < 4000)
        begin
            @(negedge sys_clk);
            n++;
        end
        chk_val("irq", 1, irq === 1'b1);
    endtask : wait_irq

    task automatic run(input int t, input int m);
        int f, t_en;
        logic [7:0] lo1, lo2;
        logic [3:0] lo_a;
        lo1 = 8'(($urandom % 32) * 2 + 1);
        lo2 = 8'(($urandom % 32) * 2 + 1);
        lo_a = 4'(`IDX_T1_LOW + 2 * t);
        f = t ? 3 * ((m == 1) ? SDIV : FDIV) : 2 * ((m == 2) ? FDIV : SDIV);
        wr(`IDX_OP_CTRL, 8'h00);
        wr(`IDX_CLK_MODE, 8'(m));
        wr(lo_a, lo1);
        wr(4'(`IDX_T1_HIGH + 2 * t), 8'h01);
        wr(`IDX_IRQ_STATUS, 8'h03);
        wr(`IDX_IRQ_MASK, t ? 8'h01 : 8'h02);
        wr(`IDX_IRQ_ENABLE, t ? 8'h02 : 8'h04);
        rises = {};
        wr(`IDX_OP_CTRL, t ? 8'h08 : 8'h04);
        t_en = cyc;
        exp_reg[`IDX_IRQ_STATUS] = t ? 1 : 2;
        for (int i = 0; i < 3; i++)
        begin
            wait_irq();
            rd_chk(`IDX_IRQ_STATUS);
            wr(`IDX_IRQ_STATUS, 8'h03);
            if (i == 0)
                wr(lo_a, lo2);
        end
        exp_reg[`IDX_IRQ_STATUS] = 0;
        if (m == 0)
            chk_val("first", 1, rises[0] - t_en <= 12);
        chk_val("span", (257 + lo1) * f / 2, rises[1] - rises[0]);
        chk_val("span", (257 + lo2) * f / 2, rises[2] - rises[1]);
        wr(`IDX_OP_CTRL, 8'h00);
        rd(4'(`IDX_COUNT_ONE + t), v0);
        repeat (20) @(posedge sys_clk);
        rd(4'(`IDX_COUNT_ONE + t), v1);
        chk_reg(4'(`IDX_COUNT_ONE + t), v0, v1);
    endtask : run

    initial
    begin
        void'($urandom(74258));
        repeat (6) @(posedge sys_clk);
        srst <= 1'b0;
        for (int a = 0; a < 16; a++)
            rd_chk(4'(a));
        for (int a = 0; a < 16; a++)
            if (a != `IDX_IRQ_STATUS)
                wr(4'(a), 8'($urandom) & wmask(a));
        u_cpu_bus_master.xfer(1'b1, `IDX_OP_CTRL, 8'hF3, 4'hE, v0);
        for (int a = 0; a < 16; a++)
            rd_chk(4'(a));
        for (int m = 0; m < 3; m++)
            for (int t = 0; t < 2; t++)
                run(t, m);
        wr(`IDX_IRQ_ENABLE, 8'h00);
        wr(`IDX_IRQ_MASK, 8'h03);
        wr(`IDX_OP_CTRL, 8'h0C);
        repeat (100) @(posedge sys_clk);
        rd_chk(`IDX_IRQ_STATUS);
        wr(`IDX_IRQ_ENABLE, 8'h06);
        // Stopped counts may sit near the top preload; wait a full period
        repeat (1100) @(posedge sys_clk);
        exp_reg[`IDX_IRQ_STATUS] = 3;
        rd_chk(`IDX_IRQ_STATUS);
        chk_val("irq", 1, irq === 1'b1);
        // Mid-run reset with both timers running
        srst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        srst <= 1'b0;
        exp_reg = '{default: 0};
        for (int a = 0; a < 16; a++)
            rd_chk(4'(a));
        close_out();
    end

    initial
    begin
        #900000;
        num_errors++;
        close_out();
    end
endmodule : tb_top
